// >>> bri_pkg.sv
// Purpose: Shared constants and types for the boot ROM select and address inversion block
// Assumes: One system clock; straps are stable while reset is held
// Notes:   Summary of operation follows
//
// Summary of operation
// - Drive the boot ROM select output whenever an access targets the firmware ROM once the straps are captured.
// - At power-up the select pin is a recovery strap, combined with two size straps.
// - Recovery strap high: pass every ROM address bit unchanged, size straps ignored.
// - Recovery low, both size straps high: invert ROM address bit 16.
// - Recovery low, size zero high, size one low: invert ROM address bit 17.
// - Recovery low, size zero low, size one high: invert ROM address bit 18.
// - Recovery and both size straps low: invert ROM address bit 15.
// - Straps are sampled on the reference oscillator clock, which must be supplied.
package bri_pkg;

  // ----------------------------------------------------------------
  // Address layout and inversion positions
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 20;
  localparam int unsigned INV_BIT_8K  = 15;
  localparam int unsigned INV_BIT_16K = 16;
  localparam int unsigned INV_BIT_32K = 17;
  localparam int unsigned INV_BIT_64K = 18;

  // Reset values of the captured straps and of the ROM address output
  localparam logic        STRAP_RST   = 1'h1;
  localparam logic [ADDR_W-1:0] MASK_RST = 20'h00000;

  // Reference clock rate, in kHz
  localparam int unsigned CLK_KHZ     = 14318;

  typedef struct packed {
    logic recovery_mode_strap;
    logic rom_size_strap_zero;
    logic rom_size_strap_one;
  } bri_strap_type;

endpackage

// >>> bri_inv_mask.sv
// Purpose: Decode captured straps into the ROM address inversion mask
// Assumes: Straps already latched and stable
// Notes:   Pure combinational decode
`timescale 1ns/100ps
module bri_inv_mask
  import bri_pkg::*;
(
  input  wire bri_strap_type      strap_i,
  output logic [ADDR_W-1:0]       mask_o
);

  always_comb begin
    mask_o = '0;
    if (!strap_i.recovery_mode_strap) begin
      case ({strap_i.rom_size_strap_zero, strap_i.rom_size_strap_one})
        2'h3:    mask_o[INV_BIT_16K] = 1'b1;
        2'h2:    mask_o[INV_BIT_32K] = 1'b1;
        2'h1:    mask_o[INV_BIT_64K] = 1'b1;
        default: mask_o[INV_BIT_8K]  = 1'b1;
      endcase
    end
    // Recovery high leaves the mask clear
  end

endmodule

// >>> bri_boot_rom.sv
// Purpose: Boot ROM select and address inversion for boot-block flash recovery
// Assumes: clk_sys_i is the reference oscillator; straps stable through reset release
// Notes:   Select pin is shared with the recovery strap; output enable held off in reset
//          until the straps are in, so the board resistor sets the pin level.
//          Inversion is fixed at capture; a new strap setting needs a new reset.
`timescale 1ns/100ps
module bri_boot_rom
  import bri_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  input  wire logic              rom_access_i,
  input  wire logic [ADDR_W-1:0] rom_addr_i,
  input  wire logic              boot_rom_select_i,
  input  wire logic              rom_size_strap_zero_i,
  input  wire logic              rom_size_strap_one_i,
  output logic                   boot_rom_select_o,
  output logic                   boot_rom_select_oe_o,
  output logic [ADDR_W-1:0]      rom_addr_o,
  output logic                   straps_valid_o
);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // ST_RESET lasts exactly one clock after release: the capture cycle
  typedef enum logic [1:0] {ST_RESET, ST_RUN} bri_state_type;

  bri_state_type     state;
  bri_strap_type     strap;
  logic [ADDR_W-1:0] inv_mask;

  // Pin must float while straps are read, so capture happens on the first
  // edge after release, before the select driver is switched on.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_RESET;
    end else begin
      case (state)
        ST_RESET: state <= ST_RUN;
        ST_RUN:   state <= ST_RUN;
        default:  state <= ST_RESET;
      endcase
    end
  end

  // Reset value means recovery, so no bit is inverted until the pins are read
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap <= '{STRAP_RST, STRAP_RST, STRAP_RST};
    end else if (state == ST_RESET) begin
      strap <= '{boot_rom_select_i, rom_size_strap_zero_i, rom_size_strap_one_i};
    end
  end

  // Decode sits before the address flops, so they always see a settled mask
  bri_inv_mask u_inv_mask (
    .strap_i (strap),
    .mask_o  (inv_mask)
  );

  // ----------------------------------------------------------------
  // ROM access path
  // ----------------------------------------------------------------
  // Drive of the shared pin starts only after the straps are in, so the
  // board's strap level is what gets sampled at capture.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_rom_select_oe_o <= 1'b0;
    end else begin
      boot_rom_select_oe_o <= (state == ST_RUN);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      straps_valid_o <= 1'b0;
    end else begin
      straps_valid_o <= (state == ST_RUN);
    end
  end

  // Accesses seen before capture are refused: the pin is still a strap then
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_rom_select_o <= 1'b0;
    end else begin
      boot_rom_select_o <= (state == ST_RUN) && rom_access_i;
    end
  end

  // Registered so the ROM sees a clean address; costs one cycle of latency
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rom_addr_o <= MASK_RST;
    end else begin
      rom_addr_o <= rom_addr_i ^ inv_mask;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // One-hot word with a single ROM address bit set
  function automatic logic [ADDR_W-1:0] bit_word(int unsigned pos);
    logic [ADDR_W-1:0] word;
    word      = '0;
    word[pos] = 1'b1;
    return word;
  endfunction

  // Cycles since reset release, saturating at three; read by the checks only
  logic [1:0] rel_cnt;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rel_cnt <= 2'h0;
    end else if (rel_cnt != 2'h3) begin
      rel_cnt <= rel_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Select pin and its output enable
  // ----------------------------------------------------------------
  a_select_follows: assert property ((state == ST_RUN && rom_access_i)
      |=> boot_rom_select_o)
    else $error("select not driven for ROM access");

  a_select_idle: assert property (!rom_access_i |=> !boot_rom_select_o)
    else $error("select driven without access");

  a_select_refused: assert property ((state == ST_RESET)
      |=> !boot_rom_select_o)
    else $error("select driven before straps captured");

  a_oe_capture: assert property ((state == ST_RESET)
      |=> !boot_rom_select_oe_o)
    else $error("select pin driven while straps are read");

  a_oe_running: assert property ((state == ST_RUN)
      |=> boot_rom_select_oe_o)
    else $error("select pin not driven after capture");

  // ----------------------------------------------------------------
  // Address inversion
  // ----------------------------------------------------------------
  a_recovery_pass: assert property ((straps_valid_o && strap.recovery_mode_strap)
      |=> rom_addr_o == $past(rom_addr_i))
    else $error("address altered in recovery mode");

  a_inv_16k: assert property ((straps_valid_o && strap == 3'h3)
      |=> rom_addr_o == ($past(rom_addr_i) ^ bit_word(INV_BIT_16K)))
    else $error("bit 16 not inverted");

  a_inv_32k: assert property ((straps_valid_o && strap == 3'h2)
      |=> rom_addr_o == ($past(rom_addr_i) ^ bit_word(INV_BIT_32K)))
    else $error("bit 17 not inverted");

  a_inv_64k: assert property ((straps_valid_o && strap == 3'h1)
      |=> rom_addr_o == ($past(rom_addr_i) ^ bit_word(INV_BIT_64K)))
    else $error("bit 18 not inverted");

  a_inv_8k: assert property ((straps_valid_o && strap == 3'h0)
      |=> rom_addr_o == ($past(rom_addr_i) ^ bit_word(INV_BIT_8K)))
    else $error("bit 15 not inverted");

  // At most one bit may ever be flipped, whatever the straps read
  a_mask_single: assert property (straps_valid_o |-> $onehot0(inv_mask))
    else $error("more than one address bit inverted");

  // Bits outside the four inversion positions must never change
  a_addr_other_bits: assert property (rst_b_i
      |=> ((rom_addr_o ^ $past(rom_addr_i)) & 20'h87FFF) == 20'h00000)
    else $error("address bit outside the inversion set changed");

  // ----------------------------------------------------------------
  // Strap capture and hold
  // ----------------------------------------------------------------
  a_strap_capture: assert property ((rst_b_i && state == ST_RESET)
      |=> strap.recovery_mode_strap == $past(boot_rom_select_i))
    else $error("recovery strap not captured");

  a_size_capture: assert property ((rst_b_i && state == ST_RESET)
      |=> strap.rom_size_strap_zero == $past(rom_size_strap_zero_i)
          && strap.rom_size_strap_one == $past(rom_size_strap_one_i))
    else $error("size straps not captured");

  // Size pins may move after capture; the captured copy must not
  a_strap_hold: assert property (straps_valid_o |=> $stable(strap))
    else $error("straps changed after capture");

  a_inv_stable: assert property (straps_valid_o |=> $stable(inv_mask))
    else $error("inversion changed after capture");

  // Capture happens once; only a reset brings the machine back
  a_capture_once: assert property ((state == ST_RUN) |=> (state == ST_RUN))
    else $error("capture state entered again without reset");

  a_valid_sticky: assert property (straps_valid_o |=> straps_valid_o)
    else $error("straps valid dropped without reset");

  // Straps are read at the first edge after release, drive starts at the second
  a_valid_timing: assert property ((rel_cnt == 2'h2) |-> straps_valid_o)
    else $error("straps not valid two cycles after release");

  a_valid_early: assert property ((rel_cnt < 2'h2) |-> !straps_valid_o)
    else $error("straps valid before capture");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  // Main scenarios: recovery pass-through and each inversion setting
  c_recovery: cover property (straps_valid_o && strap.recovery_mode_strap && rom_access_i);
  c_inv_16k:  cover property (straps_valid_o && strap == 3'h3 && rom_access_i);
  c_inv_32k:  cover property (straps_valid_o && strap == 3'h2 && rom_access_i);
  c_inv_64k:  cover property (straps_valid_o && strap == 3'h1 && rom_access_i);
  c_inv_8k:   cover property (straps_valid_o && strap == 3'h0 && rom_access_i);

endmodule

// >>> bri_rom_model.sv
// Purpose: Board side of the shared select and recovery strap pin
// Assumes: A board resistor sets the pin to the strap level
// Notes:   Strap level shows only while the device is not driving
`timescale 1ns/100ps
module bri_rom_model (
  input  wire logic strap_i,
  input  wire logic sel_i,
  input  wire logic oe_i,
  output wire logic pin_o
);
  assign pin_o = oe_i ? sel_i : strap_i;
endmodule

// >>> bri_boot_rom_tb_top.sv
// Purpose: Self-checking bench for boot ROM select and inversion
// Assumes: Straps stay on the pins across reset release
// Notes:   One reset for each strap setting
`timescale 1ns/100ps
module bri_boot_rom_tb_top
  import bri_pkg::*;
;
  logic              clk_sys_i = 1'b0;
  logic              rst_b_i, acc, rec, s0, s1, sel, oe, valid;
  logic [ADDR_W-1:0] addr, aout;
  wire               pin;
  int                error_cnt = 0;
  int                checked = 0;

  bri_rom_model rom (.strap_i(rec), .sel_i(sel), .oe_i(oe), .pin_o(pin));
  bri_boot_rom DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .rom_access_i(acc),
    .rom_addr_i(addr), .boot_rom_select_i(pin), .rom_size_strap_zero_i(s0),
    .rom_size_strap_one_i(s1), .boot_rom_select_o(sel), .boot_rom_select_oe_o(oe),
    .rom_addr_o(aout), .straps_valid_o(valid));

  initial forever #20 clk_sys_i = ~clk_sys_i;

  task automatic chk(string nm, logic [ADDR_W-1:0] seen, logic [ADDR_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Size straps flip after capture to prove they are held
  task automatic run_mode(logic [2:0] st, int b);
    logic [ADDR_W-1:0] m;
    m = (b < 0) ? 20'h00000 : (20'h00001 << b);
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    {rec, s0, s1} <= st;
    repeat (5) @(posedge clk_sys_i);
    #1 chk("pin", pin, st[2]);
    chk("oe", oe, 1'b0);
    chk("valid", valid, 1'b0);
    chk("addr", aout, 20'h00000);
    @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    acc <= 1'b1;
    @(posedge clk_sys_i);
    #1 chk("sel", sel, 1'b0);
    chk("oe", oe, 1'b0);
    chk("valid", valid, 1'b0);
    @(posedge clk_sys_i);
    addr <= 20'hA5A5A;
    {s0, s1} <= ~st[1:0];
    @(posedge clk_sys_i);
    acc <= 1'b0;
    addr <= 20'h5A5A5;
    #1 chk("sel", sel, 1'b1);
    chk("pin", pin, 1'b1);
    chk("oe", oe, 1'b1);
    chk("valid", valid, 1'b1);
    chk("addr", aout, 20'hA5A5A ^ m);
    @(posedge clk_sys_i);
    #1 chk("sel", sel, 1'b0);
    chk("addr", aout, 20'h5A5A5 ^ m);
  endtask

  initial begin
    rst_b_i = 1'b0;
    acc = 1'b0;
    addr = 20'h00000;
    {rec, s0, s1} = 3'b100;
    repeat (5) @(posedge clk_sys_i);
    run_mode(3'b100, -1);
    run_mode(3'b111, -1);
    run_mode(3'b011, 16);
    run_mode(3'b010, 17);
    run_mode(3'b001, 18);
    run_mode(3'b000, 15);
    report_and_stop;
  end

  // About 71 cycles are needed; allow far more
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
endmodule
